// file: fpc_fan_model.sv
// Purpose: four three-pin fans with tach outputs
// Assumes: tach pulled up when the fan is unpowered or stalled
// Notes:   tach toggles every 16 cycles while powered
`timescale 1ns/1ps
module fpc_fan_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] pwr_n,
  input  wire logic       stall,
  output logic      [3:0] tach = 4'hF
);
  logic [3:0] div_r = 4'h0;
  always_ff @(posedge sys_clk) begin
    div_r <= div_r + 4'h1;
    for (int i = 0; i < 4; i++) begin
      if (pwr_n[i] || stall) begin
        tach[i] <= 1'b1; // one tach per fan, idle high
      end else if (div_r == 4'hF) begin
        tach[i] <= ~tach[i];
      end
    end
  end
endmodule

// file: fpc_pkg.sv
// Purpose: constants and types for the four-channel fan power controller
// Assumes: 250 MHz sys_clk, APB register access
// Notes:   register byte offsets are word aligned
package fpc_pkg;
  localparam int          NUM_FANS      = 4;
  localparam int          CLK_HZ        = 250_000_000;
  localparam int          PWM_HZ        = 18;
  localparam int          PWM_STEPS     = 100;
  localparam int          PWM_STEP_CYC  = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int          WIN_MS        = 125;
  localparam int          WIN_CYC       = (CLK_HZ / 1000) * WIN_MS;
  localparam int          SEQ_MS        = 500;
  localparam int          SEQ_CYC       = (CLK_HZ / 1000) * SEQ_MS;
  localparam int          GLITCH_US     = 1;
  localparam int          GLITCH_UNIT   = (CLK_HZ / 1_000_000) * GLITCH_US;
  localparam int          FS_UNIT_MS    = 125;
  localparam int          FS_UNIT_CYC   = (CLK_HZ / 1000) * FS_UNIT_MS;
  localparam logic [6:0]  DUTY_FULL     = 7'h64;
  localparam logic [7:0]  NO_READING    = 8'hFF;
  // register byte offsets
  localparam logic [7:0]  DUTY_OFS      = 8'h00;
  localparam logic [7:0]  CTRL_OFS      = 8'h10;
  localparam logic [7:0]  GLITCH_OFS    = 8'h14;
  localparam logic [7:0]  FSTIME_OFS    = 8'h18;
  localparam logic [7:0]  STAT_OFS      = 8'h1C;
  localparam logic [7:0]  CLR_OFS       = 8'h20;
  localparam logic [7:0]  IEN_OFS       = 8'h24;
  localparam logic [7:0]  SPEED_OFS     = 8'h30;
  // control field positions
  localparam int          CTRL_REP_LSB  = 0;
  localparam int          CTRL_FS_LSB   = 4;
  // status field positions
  localparam int          ST_REP_LSB    = 0;
  localparam int          ST_FS_LSB     = 4;
  // reset values
  localparam logic [7:0]  GLITCH_RST    = 8'h01;
  localparam logic [7:0]  FSTIME_RST    = 8'h08;
  localparam logic [31:0] BOOT_DUTY_RST = 32'h64646464;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } fpc_apb_req_type;

  typedef struct packed {
    logic [7:0]  cycles;
    logic [15:0] ticks;
  } fpc_speed_type;
endpackage

// file: fpc_props.sv
// Purpose: port checks for the fan power controller
// Assumes: one clock, async active-low reset
// Notes:   bound onto fpc_top
`timescale 1ns/1ps
module fpc_props
  import fpc_pkg::*;
#(
  parameter int NUM_FANS = 4,
  parameter int SEQ_CYC  = 800
) (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                clk_en,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                irq,
  input wire logic [NUM_FANS-1:0] fan_tach,
  input wire logic [NUM_FANS-1:0] fan_pwm_o,
  input wire logic [NUM_FANS-1:0] fan_pwm_oe_n
);
  logic [31:0] up_r;
  logic [31:0] up_nxt;
  logic        ien_r;
  logic        ien_nxt;
  logic        setup;
  logic        unmap;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  assign setup = psel && !penable;
  assign unmap = !(paddr inside {DUTY_OFS, CTRL_OFS, GLITCH_OFS, FSTIME_OFS,
                 STAT_OFS, CLR_OFS, IEN_OFS}
                 || (!pwrite && paddr inside {8'h30, 8'h34, 8'h38, 8'h3C}));
  always_comb begin
    up_nxt  = (up_r == 32'hFFFFFFFF) ? up_r : up_r + 32'h1;
    ien_nxt = ien_r | (setup && pwrite && paddr == IEN_OFS);
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_r  <= 32'h0;
      ien_r <= 1'b0;
    end else begin
      up_r  <= up_nxt;
      ien_r <= ien_nxt;
    end
  end
  AST_PWM_O_ZERO: assert property (fan_pwm_o == '0)
    else $error("fan_pwm_o driven high");
  AST_READY_NEXT: assert property (setup |=> pready)
    else $error("no pready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(setup))
    else $error("pready without setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ERR_DECODE: assert property (setup |=> pslverr == $past(unmap))
    else $error("pslverr does not match decode");
  AST_IRQ_OFF: assert property (!ien_r |-> !irq)
    else $error("irq before any enable");
  AST_SOFT_START: assert property (up_r < SEQ_CYC |->
    $countones(~fan_pwm_oe_n) <= 1)
    else $error("fans started together");
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
  COV_FAN_ON: cover property ($fell(fan_pwm_oe_n[0]));
endmodule
bind fpc_top fpc_props #(.NUM_FANS(NUM_FANS), .SEQ_CYC(SEQ_CYC))
  fpc_props_inst (.sys_clk, .reset_n, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .fan_tach,
  .fan_pwm_o, .fan_pwm_oe_n);

// file: fpc_top.sv
// Purpose: four-channel fan pwm, tach measure, fail-safe and soft start
// Assumes: fan_tach pins asynchronous; APB on sys_clk
// Notes:   fan_pwm_oe_n low sinks the fan ground return
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module fpc_top #(
  parameter int          NUM_FANS  = fpc_pkg::NUM_FANS,
  parameter int          WIN_CYC   = fpc_pkg::WIN_CYC,
  parameter int          SEQ_CYC   = fpc_pkg::SEQ_CYC,
  parameter int          FS_UNIT   = fpc_pkg::FS_UNIT_CYC,
  parameter int          STEP_CYC  = fpc_pkg::PWM_STEP_CYC,
  parameter logic [31:0] BOOT_DUTY = fpc_pkg::BOOT_DUTY_RST
) (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire logic [NUM_FANS-1:0] fan_tach,
  output logic      [NUM_FANS-1:0] fan_pwm_o,
  output logic      [NUM_FANS-1:0] fan_pwm_oe_n
);
  import fpc_pkg::*;

  if (NUM_FANS != 4 || WIN_CYC < 2 || SEQ_CYC < WIN_CYC || STEP_CYC < 1
      || BOOT_DUTY[7:0] > {1'b0, DUTY_FULL}
      || BOOT_DUTY[15:8] > {1'b0, DUTY_FULL}
      || BOOT_DUTY[23:16] > {1'b0, DUTY_FULL}
      || BOOT_DUTY[31:24] > {1'b0, DUTY_FULL}) begin : g_param_chk
    $error("fpc_top: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  fpc_apb_req_type        req;
  logic [6:0]             duty_r    [NUM_FANS], duty_nxt    [NUM_FANS];
  logic [NUM_FANS-1:0]    rep_en_r, rep_en_nxt, fs_en_r, fs_en_nxt;
  logic [7:0]             glitch_r, glitch_nxt, fstime_r, fstime_nxt;
  logic [7:0]             stat_r, stat_nxt, ien_r, ien_nxt;
  logic [31:0]            prdata_nxt;
  logic                   pready_nxt, pslverr_nxt;
  logic                   duty_wr;
  fpc_speed_type          speed_r   [NUM_FANS], speed_nxt   [NUM_FANS];

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  function automatic logic [6:0] clip_duty(input logic [7:0] v);
    clip_duty = (v > {1'b0, DUTY_FULL}) ? DUTY_FULL : v[6:0];
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    addr_hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // tach sync and glitch filter
  logic [NUM_FANS-1:0] tach_s1_r, tach_s2_r, tach_f_r, tach_f_nxt;
  logic [15:0]         gl_cnt_r [NUM_FANS], gl_cnt_nxt [NUM_FANS];
  logic [NUM_FANS-1:0] tach_edge;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tach_s1_r <= '1;
      tach_s2_r <= '1;
    end else if (clk_en) begin
      tach_s1_r <= fan_tach;
      tach_s2_r <= tach_s1_r;
    end
  end

  always_comb begin
    tach_f_nxt = tach_f_r;
    tach_edge  = '0;
    for (int i = 0; i < NUM_FANS; i++) begin
      gl_cnt_nxt[i] = 16'h0000;
      if (tach_s2_r[i] != tach_f_r[i]) begin
        gl_cnt_nxt[i] = gl_cnt_r[i] + 16'h0001;
        if (gl_cnt_r[i] >= 16'(glitch_r) * 16'(GLITCH_UNIT)) begin
          tach_f_nxt[i] = tach_s2_r[i];
          tach_edge[i]  = 1'b1;
          gl_cnt_nxt[i] = 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tach_f_r <= '1;
      for (int i = 0; i < NUM_FANS; i++) gl_cnt_r[i] <= 16'h0000;
    end else if (clk_en) begin
      tach_f_r <= tach_f_nxt;
      for (int i = 0; i < NUM_FANS; i++) gl_cnt_r[i] <= gl_cnt_nxt[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm timebase, soft start, fail-safe timer
  logic [31:0]         step_r, step_nxt, win_r, win_nxt;
  logic [6:0]          phase_r, phase_nxt;
  logic [31:0]         ss_cnt_r, ss_cnt_nxt, fs_cnt_r, fs_cnt_nxt;
  logic [7:0]          fs_units_r, fs_units_nxt;
  logic [2:0]          ss_idx_r, ss_idx_nxt;
  logic [NUM_FANS-1:0] started_r, started_nxt;
  logic                fs_trip_r, fs_trip_nxt;
  logic [1:0]          meas_r, meas_nxt;
  logic                stretch_r, stretch_nxt, glok_r, glok_nxt;
  logic [1:0]          edges_r, edges_nxt;
  logic [NUM_FANS-1:0] pwm_nxt;
  logic                win_end;

  always_comb begin
    step_nxt    = step_r + 32'h1;
    phase_nxt   = phase_r;
    if (step_r >= 32'(STEP_CYC - 1)) begin
      step_nxt  = 32'h0;
      phase_nxt = (phase_r == DUTY_FULL - 7'h01) ? 7'h00 : phase_r + 7'h01;
    end
    // soft start: one fan per interval, skipping fans that are off
    ss_cnt_nxt  = ss_cnt_r;
    ss_idx_nxt  = ss_idx_r;
    started_nxt = started_r;
    if (ss_idx_r < 3'(NUM_FANS)) begin
      if (duty_r[ss_idx_r[1:0]] == 7'h00) begin
        ss_idx_nxt = ss_idx_r + 3'h1;
      end else if (ss_cnt_r == 32'h0) begin
        started_nxt[ss_idx_r[1:0]] = 1'b1;
        ss_cnt_nxt = 32'(SEQ_CYC - 1);
        ss_idx_nxt = ss_idx_r + 3'h1;
      end
    end
    if (ss_cnt_r != 32'h0) ss_cnt_nxt = ss_cnt_r - 32'h1;
    // fail-safe timeout in eighth-second units
    fs_cnt_nxt   = fs_cnt_r + 32'h1;
    fs_units_nxt = fs_units_r;
    fs_trip_nxt  = fs_trip_r;
    if (fs_cnt_r >= 32'(FS_UNIT - 1)) begin
      fs_cnt_nxt = 32'h0;
      if (fs_units_r != 8'hFF) fs_units_nxt = fs_units_r + 8'h01;
    end
    if (fs_units_r >= fstime_r && fstime_r != 8'h00) fs_trip_nxt = 1'b1;
    if (duty_wr) begin
      fs_cnt_nxt   = 32'h0;
      fs_units_nxt = 8'h00;
      fs_trip_nxt  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement rotation and pwm outputs
  always_comb begin
    win_nxt     = win_r + 32'h1;
    meas_nxt    = meas_r;
    stretch_nxt = stretch_r;
    glok_nxt    = glok_r;
    edges_nxt   = edges_r;
    win_end     = (win_r >= 32'(WIN_CYC - 1));
    for (int i = 0; i < NUM_FANS; i++) speed_nxt[i] = speed_r[i];
    if (tach_edge[meas_r] && edges_r != 2'h3) edges_nxt = edges_r + 2'h1;
    if (win_r >= 32'(16'(glitch_r) * 16'(GLITCH_UNIT))) glok_nxt = 1'b1;
    if (stretch_r && glok_r && edges_r >= 2'h2) stretch_nxt = 1'b0;
    if (win_r != 32'h0 && tach_edge[meas_r]
        && speed_r[meas_r].cycles != 8'hFE)
      speed_nxt[meas_r].cycles = speed_r[meas_r].cycles + 8'h01;
    if (win_r == 32'h0) begin
      speed_nxt[meas_r].cycles = 8'h00;
      stretch_nxt = rep_en_r[meas_r];
      glok_nxt    = 1'b0;
      edges_nxt   = 2'h0;
    end
    if (win_end) begin
      win_nxt     = 32'h0;
      stretch_nxt = 1'b0;
      speed_nxt[meas_r].ticks = 16'(WIN_CYC >> 12);
      meas_nxt    = meas_r + 2'h1;
    end
    for (int i = 0; i < NUM_FANS; i++) begin
      pwm_nxt[i] = started_r[i] && (phase_r < duty_r[i]);
      if (fs_trip_r && fs_en_r[i]) pwm_nxt[i] = started_r[i];
      if (stretch_r && meas_r == 2'(i)) pwm_nxt[i] = started_r[i];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_r       <= 32'h0;
      phase_r      <= 7'h00;
      ss_cnt_r     <= 32'h0;
      ss_idx_r     <= 3'h0;
      started_r    <= '0;
      fs_cnt_r     <= 32'h0;
      fs_units_r   <= 8'h00;
      fs_trip_r    <= 1'b0;
      win_r        <= 32'h0;
      meas_r       <= 2'h0;
      stretch_r    <= 1'b0;
      glok_r       <= 1'b0;
      edges_r      <= 2'h0;
      fan_pwm_oe_n <= '1;
      fan_pwm_o    <= '0;
      for (int i = 0; i < NUM_FANS; i++) speed_r[i] <= '{NO_READING, 16'h0};
    end else if (clk_en) begin
      step_r       <= step_nxt;
      phase_r      <= phase_nxt;
      ss_cnt_r     <= ss_cnt_nxt;
      ss_idx_r     <= ss_idx_nxt;
      started_r    <= started_nxt;
      fs_cnt_r     <= fs_cnt_nxt;
      fs_units_r   <= fs_units_nxt;
      fs_trip_r    <= fs_trip_nxt;
      win_r        <= win_nxt;
      meas_r       <= meas_nxt;
      stretch_r    <= stretch_nxt;
      glok_r       <= glok_nxt;
      edges_r      <= edges_nxt;
      fan_pwm_oe_n <= ~pwm_nxt;
      fan_pwm_o    <= '0;
      for (int i = 0; i < NUM_FANS; i++) speed_r[i] <= speed_nxt[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb registers and interrupt
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) duty_nxt[i] = duty_r[i];
    rep_en_nxt  = rep_en_r;
    fs_en_nxt   = fs_en_r;
    glitch_nxt  = glitch_r;
    fstime_nxt  = fstime_r;
    ien_nxt     = ien_r;
    stat_nxt    = stat_r;
    prdata_nxt  = 32'h0;
    pslverr_nxt = 1'b0;
    pready_nxt  = req.sel && !req.enable;
    duty_wr     = 1'b0;
    if (req.sel && !req.enable) begin
      if (req.write) begin
        if (addr_hit(req.addr, DUTY_OFS)) begin
          for (int i = 0; i < NUM_FANS; i++)
            duty_nxt[i] = clip_duty(req.wdata[8*i +: 8]);
          duty_wr = 1'b1;
        end else if (addr_hit(req.addr, CTRL_OFS)) begin
          rep_en_nxt = req.wdata[CTRL_REP_LSB +: NUM_FANS];
          fs_en_nxt  = req.wdata[CTRL_FS_LSB +: NUM_FANS];
        end else if (addr_hit(req.addr, GLITCH_OFS)) glitch_nxt = req.wdata[7:0];
        else if (addr_hit(req.addr, FSTIME_OFS)) fstime_nxt = req.wdata[7:0];
        else if (addr_hit(req.addr, CLR_OFS)) stat_nxt = stat_r & ~req.wdata[7:0];
        else if (addr_hit(req.addr, IEN_OFS)) ien_nxt = req.wdata[7:0];
        else if (!addr_hit(req.addr, STAT_OFS)) pslverr_nxt = 1'b1;
      end else begin
        if (addr_hit(req.addr, DUTY_OFS))
          prdata_nxt = {1'b0, duty_r[3], 1'b0, duty_r[2],
                        1'b0, duty_r[1], 1'b0, duty_r[0]};
        else if (addr_hit(req.addr, CTRL_OFS))
          prdata_nxt = {24'h0, fs_en_r, rep_en_r};
        else if (addr_hit(req.addr, GLITCH_OFS)) prdata_nxt = {24'h0, glitch_r};
        else if (addr_hit(req.addr, FSTIME_OFS)) prdata_nxt = {24'h0, fstime_r};
        else if (addr_hit(req.addr, STAT_OFS)) prdata_nxt = {24'h0, stat_r};
        else if (addr_hit(req.addr, IEN_OFS)) prdata_nxt = {24'h0, ien_r};
        else if (req.addr[7:4] == SPEED_OFS[7:4] && req.addr[1:0] == 2'h0)
          prdata_nxt = {8'h0, speed_r[req.addr[3:2]]};
        else if (!addr_hit(req.addr, CLR_OFS)) pslverr_nxt = 1'b1;
      end
    end
    // events set after clear so a coincident event is kept
    if (win_end && rep_en_r[meas_r]) stat_nxt[ST_REP_LSB + 32'(meas_r)] = 1'b1;
    if (!fs_trip_r && fs_trip_nxt && fs_en_r != '0) stat_nxt[ST_FS_LSB] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_FANS; i++)
        duty_r[i] <= BOOT_DUTY[8*i +: 7];
      rep_en_r <= '0;
      fs_en_r  <= '0;
      glitch_r <= GLITCH_RST;
      fstime_r <= FSTIME_RST;
      stat_r   <= 8'h00;
      ien_r    <= 8'h00;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_FANS; i++) duty_r[i] <= duty_nxt[i];
      rep_en_r <= rep_en_nxt;
      fs_en_r  <= fs_en_nxt;
      glitch_r <= glitch_nxt;
      fstime_r <= fstime_nxt;
      stat_r   <= stat_nxt;
      ien_r    <= ien_nxt;
      prdata   <= prdata_nxt;
      pready   <= pready_nxt;
      pslverr  <= pslverr_nxt;
      irq      <= |(stat_nxt & ien_nxt);
    end
  end
endmodule

// file: fpc_top_tb.sv
// Purpose: register level test of the fan power controller
// Assumes: short window, step, sequence and timeout counts
// Notes:   apb master tasks drive after each rising edge
`timescale 1ns/1ps
module fpc_top_tb;
  import fpc_pkg::*;
  localparam int WIN = 200;
  localparam int SEQ = 800;
  localparam int FSU = 400;
  localparam int STP = 2;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        stall   = 1'b0;
  logic        clk_en  = 1'b1;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  fan_tach;
  logic [3:0]  fan_pwm_o;
  logic [3:0]  fan_pwm_oe_n;
  int          failures = 0;
  int          total_checks = 0;
  int          cnt;
  int          duty_on [4] = '{0, 100 * STP, 25 * STP, 100 * STP};
  always #2 sys_clk = ~sys_clk;
  fpc_top #(.WIN_CYC(WIN), .SEQ_CYC(SEQ), .FS_UNIT(FSU), .STEP_CYC(STP))
  fpc_top_inst (.sys_clk, .reset_n, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .fan_tach, .fan_pwm_o, .fan_pwm_oe_n);
  fpc_fan_model fpc_fan_model_inst (.sys_clk, .pwr_n(fan_pwm_oe_n),
    .stall, .tach(fan_tach));
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic er = 1'b0);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
      results();
    end
    rd = prdata;
    chk("pslverr", 32'(er), 32'(pslverr));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic ontime(int f, int n);
    cnt = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (fan_pwm_oe_n[f] === 1'b0) cnt++;
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc("duty", DUTY_OFS, BOOT_DUTY_RST);
    rdc("ctrl", CTRL_OFS, 32'h0);
    rdc("glitch", GLITCH_OFS, 32'(GLITCH_RST));
    rdc("fstime", FSTIME_OFS, 32'(FSTIME_RST));
    apb(1'b0, 8'h04, 32'h0, 1'b1);
    $display("test registers done");
    repeat (4 * SEQ + SEQ / 2) @(posedge sys_clk);
    chk("all fans on", 32'h0, 32'(fan_pwm_oe_n));
    $display("test soft start done");
    wr(DUTY_OFS, 32'hC8196400);
    rdc("duty clip", DUTY_OFS, 32'h64196400);
    for (int f = 0; f < 4; f++) begin
      ontime(f, 100 * STP);
      chk("on time", 32'(duty_on[f]), 32'(cnt));
    end
    @(posedge sys_clk);
    clk_en <= 1'b0;
    ontime(2, 100 * STP);
    chk("freeze", 32'h1, 32'(cnt == 0 || cnt == 100 * STP));
    clk_en <= 1'b1;
    $display("test duty done");
    wr(DUTY_OFS, 32'h0);
    wr(GLITCH_OFS, 32'h0);
    wr(IEN_OFS, 32'h1);
    wr(CTRL_OFS, 32'h1);
    repeat (4 * WIN) @(posedge sys_clk);
    ontime(0, 4 * WIN);
    chk("stretch", 32'h1, 32'(cnt > 0 && cnt < WIN / 2));
    ontime(1, 4 * WIN);
    chk("idle fan", 32'h0, 32'(cnt));
    wr(CLR_OFS, 32'hF);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 5 * WIN) begin
      @(posedge sys_clk);
      cnt++;
    end
    chk("irq", 32'h1, 32'(irq));
    rdc("status", STAT_OFS, 32'h1);
    apb(1'b0, SPEED_OFS, 32'h0);
    chk("tach", 32'h1, 32'(rd[23:16] != 8'h00 && rd[23:16] != NO_READING));
    wr(CLR_OFS, 32'h1);
    rdc("cleared", STAT_OFS, 32'h0);
    wr(IEN_OFS, 32'h0);
    repeat (5 * WIN) @(posedge sys_clk);
    chk("masked irq", 32'h0, 32'(irq));
    $display("test report done");
    stall <= 1'b1;
    repeat (4 * WIN) @(posedge sys_clk);
    ontime(0, 4 * WIN);
    chk("stall cap", 32'h1, 32'(cnt >= WIN - 4 && cnt <= WIN));
    stall <= 1'b0;
    $display("test stall done");
    wr(CTRL_OFS, 32'h40);
    wr(FSTIME_OFS, 32'h4);
    wr(CLR_OFS, 32'h1F);
    repeat (3) begin
      wr(DUTY_OFS, 32'h0);
      ontime(2, 3 * FSU);
      chk("fs held off", 32'h0, 32'(cnt));
    end
    ontime(2, 4 * FSU + 20);
    ontime(2, WIN);
    chk("fs full on", 32'(WIN), 32'(cnt));
    rdc("fs status", STAT_OFS, 32'h10);
    $display("test fail-safe done");
    results();
  end
endmodule
